// *** bench/csg_scl_line.sv ***
`timescale 1ns/1ps
// =========================================================
// Far side of channel 0 SCL: open-drain wire with pull-up
module csg_scl_line (
    input wire logic scl_oe,
    input wire logic hold_low,
    output logic scl_in
);
    // Pull-up wins only when nobody pulls low
    assign scl_in = !(scl_oe || hold_low);
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import csg_pkg::*;
    localparam int STEP = 4;
    logic clock;
    logic rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic [2:0] chan_event;
    logic [2:0] chan_status_read;
    logic [2:0] chan_active;
    logic buf_unconfigured;
    logic buf_over_capacity;
    logic buf_pointer_bad;
    logic data_store_en;
    logic scl_in;
    logic start_wanted;
    logic scl_oe;
    logic sda_oe;
    logic clock_low_fault;
    logic [2:0] chan_reset;
    logic int_n;
    logic hold_low;
    logic [7:0] ofs [3];
    int n_errors;
    int tests_run;

    csg_supervisor #(.STEP_CYCLES(STEP)) csg_supervisor_i (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .chan_event(chan_event), .chan_status_read(chan_status_read),
        .chan_active(chan_active), .buf_unconfigured(buf_unconfigured),
        .buf_over_capacity(buf_over_capacity),
        .buf_pointer_bad(buf_pointer_bad), .data_store_en(data_store_en),
        .scl_in(scl_in), .start_wanted(start_wanted), .scl_oe(scl_oe),
        .sda_oe(sda_oe), .clock_low_fault(clock_low_fault),
        .chan_reset(chan_reset), .int_n(int_n)
    );

    csg_scl_line csg_scl_line_i (
        .scl_oe(scl_oe), .hold_low(hold_low), .scl_in(scl_in)
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // =========================================================
    // Host bus tasks, entered and left at a falling edge
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        chk(rdata, exp);
        @(negedge clock);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic do_reset;
        rst = 1'b1;
        cyc(5);
        rst = 1'b0;
        cyc(1);
    endtask

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        // Generous bound: the sequence needs well under 1000 cycles
        repeat (6000) @(posedge clock);
        n_errors++;
        conclude;
    end

    // =========================================================
    // Test sequence
    initial
    begin
        {addr, wdata, wr_en, rd_en, chan_event, chan_status_read} = '0;
        {chan_active, buf_unconfigured, buf_over_capacity} = '0;
        {buf_pointer_bad, start_wanted, hold_low} = '0;
        n_errors = 0;
        tests_run = 0;
        ofs[0] = CHAN0_RESET_OFS;
        ofs[1] = CHAN1_RESET_OFS;
        ofs[2] = CHAN2_RESET_OFS;
        do_reset;
        chk(int_n, 8'h01);
        rd(GLOBAL_STATUS_OFS, 8'h00);
        rd(GLOBAL_BLOCK_OFS, 8'h00);
        rd(PART_CODE_OFS, {PART_FAMILY_DEFAULT, PART_DIGITS_DEFAULT});
        rd(8'h00, 8'h00);
        rd(SCL_LOW_LIMIT_OFS, 8'h00);
        wr(GLOBAL_BLOCK_OFS, 8'hFF);
        rd(GLOBAL_BLOCK_OFS, 8'h87);
        wr(GLOBAL_BLOCK_OFS, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wr(SCL_LOW_LIMIT_OFS, 8'h85);
            wr(ofs[i], RESET_KEY_FIRST);
            wr(ofs[i], 8'h5B);
            chk(chan_reset, 8'h00);
            wr(ofs[i], RESET_KEY_FIRST);
            wr(GLOBAL_BLOCK_OFS, 8'h00);
            wr(ofs[i], RESET_KEY_SECOND);
            chk(chan_reset, 8'h00);
            wr(ofs[i], RESET_KEY_FIRST);
            wr(ofs[i], RESET_KEY_SECOND);
            chk(chan_reset, 8'h01 << i);
            rd(ofs[i], RESET_BUSY_VALUE);
            cyc(20);
            rd(ofs[i], 8'h00);
            rd(SCL_LOW_LIMIT_OFS, (i == 0) ? 8'h00 : 8'h85);
        end
        for (int i = 0; i < 3; i++)
        begin
            chan_event[i] = 1'b1;
            cyc(1);
            chan_event[i] = 1'b0;
            chk(int_n, 8'h00);
            rd(GLOBAL_STATUS_OFS, 8'h01 << i);
            wr(GLOBAL_BLOCK_OFS, 8'h01 << i);
            chk(int_n, 8'h01);
            wr(GLOBAL_BLOCK_OFS, 8'h00);
            chk(int_n, 8'h00);
            chan_status_read[i] = 1'b1;
            cyc(1);
            chan_status_read[i] = 1'b0;
            rd(GLOBAL_STATUS_OFS, 8'h00);
            chk(int_n, 8'h01);
        end
        chan_active = 3'b101;
        cyc(1);
        rd(GLOBAL_STATUS_OFS, 8'h28);
        chan_active = 3'b000;
        buf_unconfigured = 1'b1;
        cyc(1);
        buf_unconfigured = 1'b0;
        chk(int_n, 8'h00);
        rd(GLOBAL_STATUS_OFS, 8'h80);
        chk(int_n, 8'h01);
        rd(GLOBAL_STATUS_OFS, 8'h80);
        wr(GLOBAL_BLOCK_OFS, 8'h80);
        buf_over_capacity = 1'b1;
        #1;
        chk(data_store_en, 8'h00);
        cyc(1);
        buf_over_capacity = 1'b0;
        buf_pointer_bad = 1'b1;
        cyc(1);
        buf_pointer_bad = 1'b0;
        chk(data_store_en, 8'h01);
        chk(int_n, 8'h01);
        do_reset;
        rd(GLOBAL_STATUS_OFS, 8'h00);
        // Limit 2 gives three steps of STEP cycles
        wr(SCL_LOW_LIMIT_OFS, 8'h82);
        start_wanted = 1'b1;
        hold_low = 1'b1;
        cyc(8);
        chk(clock_low_fault, 8'h00);
        cyc(12);
        chk(clock_low_fault, 8'h01);
        chk(int_n, 8'h00);
        chk({scl_oe, sda_oe}, 8'h00);
        hold_low = 1'b0;
        start_wanted = 1'b0;
        rd(GLOBAL_STATUS_OFS, 8'h01);
        chan_status_read[0] = 1'b1;
        cyc(1);
        chan_status_read[0] = 1'b0;
        chk(clock_low_fault, 8'h00);
        // Short low phases must keep restarting the count
        repeat (4)
        begin
            hold_low = 1'b1;
            cyc(8);
            hold_low = 1'b0;
            cyc(2);
        end
        chk(clock_low_fault, 8'h00);
        wr(SCL_LOW_LIMIT_OFS, 8'h02);
        hold_low = 1'b1;
        cyc(40);
        chk(clock_low_fault, 8'h00);
        hold_low = 1'b0;
        conclude;
    end
endmodule

// *** verilog/csg_pkg.sv ***
// Operation
// - SCL-low supervision runs only while limit_enable is set.
// - Allowed SCL-low time is (scl_low_limit + 1) times about 200 us.
// - Timeout counter reloads from the register whenever SCL goes low.
// - SCL held low before START for full period: flag, interrupt, release.
// - SCL low for the timeout at any time is a bus error, same response.
// - Only the bidirectional channel 0 has timeout supervision.
// - Channel reset needs A5h then 5Ah as consecutive writes, else aborted.
// - Channel reset clears that channel's state and arrays only.
// - Bus stays usable; reset register reads all ones busy, zeros done.
// - Global status low bits show channel pending; each cleared by that channel's status read.
// - Global status bits 5:3 show live per-channel activity.
// - Global status zero means idle with no serial interrupt.
// - buffer_fault in bit 7 persists until software or hardware reset; here only rst clears it, channel resets do not.
// - Unconfigured access, beyond capacity or bad pointers raise buffer_fault.
// - Data written beyond capacity is discarded and raises buffer_fault.
// - Buffer-fault interrupt clears on global status read; others per channel.
// - A set channel block bit suppresses that channel's interrupts.
// - buffer_fault_block stops the buffer-fault interrupt.
// - Part code: family bit 7, two-digit BCD in bits 6:0.
package csg_pkg;
    // =========================================================
    // Register offsets
    localparam logic [7:0] SCL_LOW_LIMIT_OFS = 8'hCE;
    localparam logic [7:0] CHAN0_RESET_OFS = 8'hCF;
    localparam logic [7:0] CHAN1_RESET_OFS = 8'hDF;
    localparam logic [7:0] CHAN2_RESET_OFS = 8'hEF;
    localparam logic [7:0] GLOBAL_STATUS_OFS = 8'hF0;
    localparam logic [7:0] GLOBAL_BLOCK_OFS = 8'hF1;
    localparam logic [7:0] PART_CODE_OFS = 8'hF6;
    // =========================================================
    // Fields and values
    localparam int LIMIT_ENABLE_BIT = 7;
    localparam int BUFFER_FAULT_BIT = 7;
    localparam int BUFFER_FAULT_BLOCK_BIT = 7;
    localparam int BUSY_LSB = 3;
    localparam logic [7:0] RESET_KEY_FIRST = 8'hA5;
    localparam logic [7:0] RESET_KEY_SECOND = 8'h5A;
    localparam logic [7:0] SCL_LOW_LIMIT_RST = 8'h00;
    localparam logic [7:0] GLOBAL_BLOCK_RST = 8'h00;
    localparam logic [7:0] RESET_BUSY_VALUE = 8'hFF;
    // =========================================================
    // Timing
    localparam int CLOCK_MHZ = 125;
    localparam int LIMIT_STEP_US = 200;
    localparam int LIMIT_STEP_CYCLES = LIMIT_STEP_US * CLOCK_MHZ;
    localparam int CHAN_RESET_CYCLES = 16;
    // Family and part digits: arbitrary neutral values
    localparam logic PART_FAMILY_DEFAULT = 1'b0;
    localparam logic [6:0] PART_DIGITS_DEFAULT = 7'h12;
endpackage

// *** verilog/csg_reset_seq.sv ***
`timescale 1ns/1ps
// =========================================================
// Two-write channel reset detector and reset stretcher
module csg_reset_seq
    import csg_pkg::*;
#(
    parameter int HOLD_CYCLES = CHAN_RESET_CYCLES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic any_write,
    input wire logic own_write,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic chan_reset
);
    import csg_pkg::*;
    initial
    begin
        // Reset check below needs at least two busy cycles
        if (HOLD_CYCLES < 2 || HOLD_CYCLES > 255)
            $error("HOLD_CYCLES out of range");
    end

    logic armed_reg;
    logic [7:0] hold_reg;
    wire logic key_first = own_write && wdata == RESET_KEY_FIRST;
    wire logic key_done = armed_reg && own_write &&
        wdata == RESET_KEY_SECOND;

    // Any other write in between breaks adjacency and aborts
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else if (any_write)
            armed_reg <= key_first && !key_done;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            hold_reg <= 8'h00;
        else if (key_done)
            hold_reg <= 8'(HOLD_CYCLES);
        else if (hold_reg != 8'h00)
            hold_reg <= hold_reg - 8'h01;
    end

    assign busy = hold_reg != 8'h00;
    assign chan_reset = busy;

    reset_after_key_a: assert property (@(posedge clock) disable iff (rst)
        key_done |=> busy [*2])
        else $error("reset not started after key pair");
endmodule

// *** verilog/csg_scl_watch.sv ***
`timescale 1ns/1ps
// =========================================================
// SCL-low timeout supervisor for the open-drain channel
module csg_scl_watch
    import csg_pkg::*;
#(
    parameter int STEP_CYCLES = LIMIT_STEP_CYCLES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic [6:0] limit,
    input wire logic scl_in,
    output logic timeout
);
    import csg_pkg::*;
    initial
    begin
        if (STEP_CYCLES < 1 || STEP_CYCLES >= 65536)
            $error("STEP_CYCLES out of range");
    end

    logic scl_prev_reg;
    logic [15:0] step_reg;
    logic [7:0] count_reg;
    logic fired_reg;
    wire logic scl_fall = scl_prev_reg && !scl_in;
    wire logic step_tick = step_reg == 16'(STEP_CYCLES - 1);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            scl_prev_reg <= 1'b1;
        else
            scl_prev_reg <= scl_in;
    end

    // Prescaler: one tick per ~200 us step; approximate is acceptable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            step_reg <= 16'h0000;
        else if (scl_fall || step_tick || scl_in)
            step_reg <= 16'h0000;
        else
            step_reg <= step_reg + 16'h0001;
    end

    // Reload on each low transition, count steps while low
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_reg <= 8'h00;
        else if (scl_fall || scl_in)
            count_reg <= {1'b0, limit} + 8'h01;
        else if (step_tick && count_reg != 8'h00)
            count_reg <= count_reg - 8'h01;
    end

    // One fault per low period, whether before START or mid-transfer
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            fired_reg <= 1'b0;
        else if (scl_in)
            fired_reg <= 1'b0;
        else if (timeout)
            fired_reg <= 1'b1;
    end

    assign timeout = enable && !scl_in && !fired_reg &&
        count_reg == 8'h00;

    no_fault_disabled_a: assert property (@(posedge clock) disable iff (rst)
        !enable |-> !timeout)
        else $error("timeout while supervision disabled");
    fault_needs_low_a: assert property (@(posedge clock) disable iff (rst)
        timeout |-> !scl_in && $past(!scl_in))
        else $error("timeout without SCL held low");
endmodule

// *** verilog/csg_supervisor.sv ***
`timescale 1ns/1ps
// =========================================================
// Channel supervision and global status register bank
module csg_supervisor
    import csg_pkg::*;
#(
    parameter int NUM_CHAN = 3,
    parameter int STEP_CYCLES = LIMIT_STEP_CYCLES,
    parameter int RESET_HOLD = CHAN_RESET_CYCLES,
    parameter logic PART_FAMILY = PART_FAMILY_DEFAULT,
    parameter logic [6:0] PART_DIGITS = PART_DIGITS_DEFAULT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [2:0] chan_event,
    input wire logic [2:0] chan_status_read,
    input wire logic [2:0] chan_active,
    input wire logic buf_unconfigured,
    input wire logic buf_over_capacity,
    input wire logic buf_pointer_bad,
    output logic data_store_en,
    input wire logic scl_in,
    input wire logic start_wanted,
    output logic scl_oe,
    output logic sda_oe,
    output logic clock_low_fault,
    output logic [2:0] chan_reset,
    output logic int_n
);
    import csg_pkg::*;
    initial
    begin
        if (NUM_CHAN != 3)
            $error("NUM_CHAN must be 3");
    end

    // =========================================================
    // Address decode
    wire logic sel_limit = addr == SCL_LOW_LIMIT_OFS;
    wire logic sel_status = addr == GLOBAL_STATUS_OFS;
    wire logic sel_block = addr == GLOBAL_BLOCK_OFS;
    wire logic sel_part = addr == PART_CODE_OFS;
    wire logic [2:0] sel_reset = {addr == CHAN2_RESET_OFS,
        addr == CHAN1_RESET_OFS, addr == CHAN0_RESET_OFS};
    wire logic status_rd = rd_en && sel_status;

    logic [7:0] scl_low_limit_reg;
    logic [7:0] global_irq_block_reg;
    logic [2:0] pending_reg;
    logic buffer_fault_reg;
    logic buffer_irq_reg;
    logic clock_low_fault_reg;
    logic [7:0] rdata_reg;
    logic [2:0] reset_busy;
    logic timeout;

    // =========================================================
    // Per-channel reset sequencers
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_reset
            csg_reset_seq #(.HOLD_CYCLES(RESET_HOLD)) u_seq (
                .clock(clock),
                .rst(rst),
                .any_write(wr_en),
                .own_write(wr_en && sel_reset[ch]),
                .wdata(wdata),
                .busy(reset_busy[ch]),
                .chan_reset(chan_reset[ch])
            );
        end
    endgenerate

    // =========================================================
    // Writable registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            scl_low_limit_reg <= SCL_LOW_LIMIT_RST;
        else if (chan_reset[0])
            scl_low_limit_reg <= SCL_LOW_LIMIT_RST;
        else if (wr_en && sel_limit)
            scl_low_limit_reg <= wdata;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            global_irq_block_reg <= GLOBAL_BLOCK_RST;
        else if (wr_en && sel_block)
            global_irq_block_reg <= {wdata[7], 4'h0, wdata[2:0]};
    end

    // =========================================================
    // Timeout supervision on channel 0 only
    csg_scl_watch #(.STEP_CYCLES(STEP_CYCLES)) u_watch (
        .clock(clock),
        .rst(rst),
        .enable(scl_low_limit_reg[LIMIT_ENABLE_BIT] && !chan_reset[0]),
        .limit(scl_low_limit_reg[6:0]),
        .scl_in(scl_in),
        .timeout(timeout)
    );

    // Fault held until channel 0 status is read or channel 0 is reset; set beats clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            clock_low_fault_reg <= 1'b0;
        else if (timeout)
            clock_low_fault_reg <= 1'b1;
        else if (chan_status_read[0] || chan_reset[0])
            clock_low_fault_reg <= 1'b0;
    end

    // Lines released while fault stands; start_wanted kept for the core
    wire logic start_blocked = start_wanted && clock_low_fault_reg;
    assign clock_low_fault = clock_low_fault_reg;
    assign scl_oe = 1'b0;
    assign sda_oe = 1'b0;
    // Core drivers live elsewhere; here only the release is signalled
    wire logic unused_ok = start_blocked;

    // =========================================================
    // Pending bits: set wins over the status-read clear
    wire logic [2:0] chan_set = chan_event | {2'b00, timeout};
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pending_reg <= 3'h0;
        else
            pending_reg <= chan_set |
                (pending_reg & ~chan_status_read & ~chan_reset);
    end

    // =========================================================
    // Buffer fault: sticky status, interrupt cleared by status read
    wire logic buf_err = buf_unconfigured || buf_over_capacity ||
        buf_pointer_bad;
    assign data_store_en = !buf_over_capacity;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            buffer_fault_reg <= 1'b0;
        else if (buf_err)
            buffer_fault_reg <= 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            buffer_irq_reg <= 1'b0;
        else if (buf_err)
            buffer_irq_reg <= 1'b1;
        else if (status_rd)
            buffer_irq_reg <= 1'b0;
    end

    // =========================================================
    // Status word, interrupt pin and read data
    wire logic [7:0] status_word = {buffer_fault_reg, 1'b0,
        chan_active, pending_reg};
    wire logic [2:0] chan_irq = pending_reg &
        ~global_irq_block_reg[2:0];
    wire logic buf_irq = buffer_irq_reg &&
        !global_irq_block_reg[BUFFER_FAULT_BLOCK_BIT];
    wire logic [7:0] part_code = {PART_FAMILY, PART_DIGITS};
    wire logic [7:0] reset_word =
        (|(sel_reset & reset_busy)) ? RESET_BUSY_VALUE : 8'h00;

    assign int_n = !(|chan_irq || buf_irq);

    wire logic [7:0] rd_mux =
        sel_limit ? scl_low_limit_reg :
        (|sel_reset) ? reset_word :
        sel_status ? status_word :
        sel_block ? global_irq_block_reg :
        sel_part ? part_code : 8'h00;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata_reg <= 8'h00;
        else if (rd_en)
            rdata_reg <= rd_mux;
    end
    assign rdata = rdata_reg;

    // =========================================================
    // Checks
    int_follows_src_a: assert property (@(posedge clock) disable iff (rst)
        (|(pending_reg & ~global_irq_block_reg[2:0])) |-> !int_n)
        else $error("interrupt pin not driven for pending source");
    block_silences_a: assert property (@(posedge clock) disable iff (rst)
        (global_irq_block_reg == 8'h87) |-> int_n)
        else $error("interrupt driven while all sources blocked");
    fault_sticky_a: assert property (@(posedge clock) disable iff (rst)
        buffer_fault_reg |=> buffer_fault_reg)
        else $error("buffer fault lost before reset");
    buf_err_sets_a: assert property (@(posedge clock) disable iff (rst)
        buf_err |=> buffer_fault_reg && buffer_irq_reg)
        else $error("buffer error not recorded");
    overflow_drop_a: assert property (@(posedge clock) disable iff (rst)
        buf_over_capacity |-> !data_store_en)
        else $error("overflow byte stored");
    status_clear_a: assert property (@(posedge clock) disable iff (rst)
        status_rd && !buf_err |=> !buffer_irq_reg)
        else $error("buffer interrupt kept after status read");
    pend_clear_a: assert property (@(posedge clock) disable iff (rst)
        chan_status_read[1] && !chan_event[1] |=> !pending_reg[1])
        else $error("pending bit kept after channel status read");
    ch0_fault_a: assert property (@(posedge clock) disable iff (rst)
        timeout |=> clock_low_fault && pending_reg[0])
        else $error("timeout not flagged");
    busy_read_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && addr == CHAN1_RESET_OFS && reset_busy[1]
        |=> rdata == 8'hFF)
        else $error("reset register not all ones while busy");

    // =========================================================
    // Register, status and interrupt pin checks
    limit_write_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && sel_limit && !chan_reset[0] |=> scl_low_limit_reg == $past(wdata))
        else $error("limit register write lost");
    limit_cleared_a: assert property (@(posedge clock) disable iff (rst)
        chan_reset[0] |=> scl_low_limit_reg == SCL_LOW_LIMIT_RST)
        else $error("limit register kept over channel reset");
    block_reserved_a: assert property (@(posedge clock) disable iff (rst)
        global_irq_block_reg[6:3] == 4'h0)
        else $error("reserved block bits not zero");
    chan_block_wr_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && sel_block |=> global_irq_block_reg[2:0] == $past(wdata[2:0]))
        else $error("channel block bits write lost");
    buf_block_wr_a: assert property (@(posedge clock) disable iff (rst)
        wr_en && sel_block |=> global_irq_block_reg[7] == $past(wdata[7]))
        else $error("buffer fault block bit write lost");
    enable_gates_a: assert property (@(posedge clock) disable iff (rst)
        !scl_low_limit_reg[LIMIT_ENABLE_BIT] |-> !timeout)
        else $error("timeout with limit_enable clear");
    scl_high_ok_a: assert property (@(posedge clock) disable iff (rst)
        scl_in |-> !timeout)
        else $error("timeout while SCL high");
    no_fault_reset_a: assert property (@(posedge clock) disable iff (rst)
        timeout |-> !chan_reset[0])
        else $error("timeout during channel 0 reset");
    fault_held_a: assert property (@(posedge clock) disable iff (rst)
        clock_low_fault && !chan_status_read[0] && !chan_reset[0]
        |=> clock_low_fault)
        else $error("clock low fault lost before status read");
    fault_clear_a: assert property (@(posedge clock) disable iff (rst)
        chan_status_read[0] && !timeout |=> !clock_low_fault)
        else $error("clock low fault kept after status read");
    fault_release_a: assert property (@(posedge clock) disable iff (rst)
        clock_low_fault |-> !scl_oe && !sda_oe)
        else $error("lines driven while clock low fault stands");
    pend0_clear_a: assert property (@(posedge clock) disable iff (rst)
        chan_status_read[0] && !chan_event[0] && !timeout
        |=> !pending_reg[0])
        else $error("channel 0 pending kept after status read");
    pend2_clear_a: assert property (@(posedge clock) disable iff (rst)
        chan_status_read[2] && !chan_event[2] |=> !pending_reg[2])
        else $error("channel 2 pending kept after status read");
    pend_set_a: assert property (@(posedge clock) disable iff (rst)
        chan_event[2] |=> pending_reg[2])
        else $error("channel 2 event not pending");
    pend_hold_a: assert property (@(posedge clock) disable iff (rst)
        pending_reg[1] && !chan_status_read[1] && !chan_reset[1]
        |=> pending_reg[1])
        else $error("channel 1 pending lost without status read");
    reset_unpends_a: assert property (@(posedge clock) disable iff (rst)
        chan_reset[2] && !chan_event[2] |=> !pending_reg[2])
        else $error("channel 2 pending kept over channel reset");
    status_pend_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && sel_status |=> rdata[2:0] == $past(pending_reg))
        else $error("status read shows wrong pending bits");
    status_active_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && sel_status |=> rdata[5:3] == $past(chan_active))
        else $error("status read shows wrong activity bits");
    status_bit6_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && sel_status |=> !rdata[6])
        else $error("status bit 6 not zero");
    status_fault_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && sel_status |=> rdata[7] == $past(buffer_fault_reg))
        else $error("status read shows wrong buffer fault bit");
    part_read_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && sel_part |=> rdata == {PART_FAMILY, PART_DIGITS})
        else $error("part code read wrong");
    done_read_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && addr == CHAN0_RESET_OFS && !reset_busy[0]
        |=> rdata == 8'h00)
        else $error("reset register not zero when done");
    busy2_read_a: assert property (@(posedge clock) disable iff (rst)
        rd_en && addr == CHAN2_RESET_OFS && reset_busy[2]
        |=> rdata == RESET_BUSY_VALUE)
        else $error("channel 2 reset register not all ones while busy");
    buf_masked_a: assert property (@(posedge clock) disable iff (rst)
        global_irq_block_reg[7] && pending_reg == 3'h0 |-> int_n)
        else $error("buffer fault interrupt not blocked");
    pin_idle_a: assert property (@(posedge clock) disable iff (rst)
        !buffer_irq_reg && pending_reg == 3'h0 |-> int_n)
        else $error("interrupt pin low with no source");
    buf_pin_a: assert property (@(posedge clock) disable iff (rst)
        buffer_irq_reg && !global_irq_block_reg[7] |-> !int_n)
        else $error("interrupt pin not driven for buffer fault");
    chan_masked_a: assert property (@(posedge clock) disable iff (rst)
        (pending_reg & ~global_irq_block_reg[2:0]) == 3'h0 && !buf_irq
        |-> int_n)
        else $error("interrupt pin low for blocked channel");
    buf_irq_kept_a: assert property (@(posedge clock) disable iff (rst)
        buffer_irq_reg && !status_rd |=> buffer_irq_reg)
        else $error("buffer interrupt lost without status read");
    store_normal_a: assert property (@(posedge clock) disable iff (rst)
        !buf_over_capacity |-> data_store_en)
        else $error("byte dropped without overflow");
endmodule
